// file: core/serial_shift_storage_outputs.sv
// Functional notes
// - Output enable high floats all eight parallel outputs.
// - Output enable low drives each output from its storage bit.
// - Clear low zeroes every shift stage at once, overriding the clock.
// - Shift edge with clear high loads data in and moves stages along.
// - Storage edge with clear high copies the whole shift register.
// - Coincident edges store the pre-shift contents, then shift.
// - Storage register holds while shifting until the next storage edge.
// - Registers hold no defined state until cleared or loaded.
module serial_shift_storage_outputs (
    // Core clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst,
    // Controller pins, asynchronous to core_clk
    input  wire logic       shift_data_in,
    input  wire logic       shift_clock,
    input  wire logic       shift_clear_n,
    input  wire logic       store_clock,
    input  wire logic       out_enable_n,
    // Three-state parallel outputs
    output logic      [7:0] par_outputs_o,
    output logic      [7:0] par_outputs_oe_n,
    // Cascade output
    output logic            cascade_out
);
    // =====================================================================
    // Pin synchronisation.
    logic [4:0] pins_s;
    logic       data_s;
    logic       sclk_s;
    logic       clr_n_s;
    logic       rclk_s;
    logic       oe_n_s;

    // Synchronisers reset to each pin's idle level, so the enable reads as
    // high and the outputs stay floating until the pin is really seen.
    pin_sync #(
        .W    (5),
        .IDLE (shift_store_pkg::PINS_IDLE)
    ) u_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .pin_in   ({shift_data_in, shift_clock, shift_clear_n,
                    store_clock, out_enable_n}),
        .pin_out  (pins_s)
    );

    // Unpack the synchronised pins.
    assign {data_s, sclk_s, clr_n_s, rclk_s, oe_n_s} = pins_s;

    // =====================================================================
    // Edge detection on the sampled link clocks.
    logic sclk_d_r;
    logic sclk_d_nxt;
    logic rclk_d_r;
    logic rclk_d_nxt;
    logic shift_edge;
    logic store_edge;

    // Rising edges are found against the previous sample.
    // The detectors reset low, the idle level of both link clocks, so the
    // release of reset cannot invent an edge while the controller rests.
    // A clock level shorter than one core cycle may be missed entirely.
    always_comb begin
        sclk_d_nxt = sclk_s;
        rclk_d_nxt = rclk_s;
        shift_edge = sclk_s & ~sclk_d_r;
        store_edge = rclk_s & ~rclk_d_r;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sclk_d_r <= shift_store_pkg::PIN_RESET;
            rclk_d_r <= shift_store_pkg::PIN_RESET;
        end else begin
            sclk_d_r <= sclk_d_nxt;
            rclk_d_r <= rclk_d_nxt;
        end
    end

    // =====================================================================
    // Shift chain and storage register.
    logic [7:0] chain_r;
    logic [7:0] chain_nxt;
    logic [7:0] store_r;
    logic [7:0] store_nxt;

    // Power-up contents are undefined on the real part; zero here keeps
    // simulation free of unknowns without claiming a usable state.
    // A pin edge acts two core cycles after it is first sampled, so the
    // registers trail the pins by about 24 ns; this bounds the link rate.
    always_comb begin
        chain_nxt = chain_r;
        store_nxt = store_r;
        // Store uses the old chain, so coincident edges behave as documented.
        if (clr_n_s && store_edge) begin
            store_nxt = chain_r;
        end
        if (!clr_n_s) begin
            chain_nxt = shift_store_pkg::CHAIN_RESET;
        end else if (shift_edge) begin
            chain_nxt = {chain_r[6:0], data_s};
        end
    end

    // Clear is level-sensitive; sampled it still wins over any shift edge.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            chain_r <= shift_store_pkg::CHAIN_RESET;
            store_r <= shift_store_pkg::STORE_RESET;
        end else begin
            chain_r <= chain_nxt;
            store_r <= store_nxt;
        end
    end

    // =====================================================================
    // Output drivers, each straight from a flip-flop.
    logic [7:0] po_r;
    logic [7:0] po_nxt;
    logic [7:0] oe_r;
    logic [7:0] oe_nxt;
    logic       casc_r;
    logic       casc_nxt;

    // The enable gates only the pins; storage and cascade ignore it.
    // Values come from the next state, so the pins move in the same cycle
    // as the storage register rather than one cycle behind it.
    always_comb begin
        po_nxt   = store_nxt;
        oe_nxt   = oe_n_s ? shift_store_pkg::OE_N_FLOAT
                          : 8'h00;
        casc_nxt = chain_nxt[7];
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            po_r   <= shift_store_pkg::STORE_RESET;
            oe_r   <= shift_store_pkg::OE_N_FLOAT;
            casc_r <= shift_store_pkg::PIN_RESET;
        end else begin
            po_r   <= po_nxt;
            oe_r   <= oe_nxt;
            casc_r <= casc_nxt;
        end
    end

    assign par_outputs_o    = po_r;
    assign par_outputs_oe_n = oe_r;
    assign cascade_out      = casc_r;

    // =====================================================================
    // Assertions.
    // Every check below except a_cascade_tail runs on the synchronised pin levels,
    // so each such one speaks about the cycle after the edge was seen, not the raw pin.
    // They are all disabled under reset, when the registers are forced.

    // The enable pin decides float or drive one cycle later.
    a_float_on_oe: assert property (
        @(posedge core_clk) disable iff (rst)
        oe_n_s |=> par_outputs_oe_n == 8'hff)
        else $error("outputs not floated while enable high");
    a_drive_on_oe: assert property (
        @(posedge core_clk) disable iff (rst)
        !oe_n_s |=> par_outputs_oe_n == 8'h00 && par_outputs_o == store_r)
        else $error("outputs not driven from storage");

    // Clear wins over shifting and leaves the storage register alone.
    a_clear_zero: assert property (
        @(posedge core_clk) disable iff (rst)
        !clr_n_s |=> chain_r == 8'h00 && cascade_out == 1'b0)
        else $error("clear did not zero chain");
    a_clear_keeps_store: assert property (
        @(posedge core_clk) disable iff (rst)
        !clr_n_s |=> $stable(store_r))
        else $error("storage changed while clear low");

    // Shift edges move the chain by one stage; with clear high, nothing else moves it.
    a_shift_step: assert property (
        @(posedge core_clk) disable iff (rst)
        clr_n_s && shift_edge |=>
        chain_r == {$past(chain_r[6:0]), $past(data_s)})
        else $error("shift step wrong");
    a_chain_hold: assert property (
        @(posedge core_clk) disable iff (rst)
        clr_n_s && !shift_edge |=> $stable(chain_r))
        else $error("chain moved without shift edge");
    a_rise_only: assert property (
        @(posedge core_clk) disable iff (rst)
        $fell(sclk_s) && clr_n_s |=> $stable(chain_r))
        else $error("falling shift clock moved chain");

    // Storage edges copy the old chain; otherwise storage holds.
    a_store_copy: assert property (
        @(posedge core_clk) disable iff (rst)
        clr_n_s && store_edge |=> store_r == $past(chain_r))
        else $error("storage copy wrong");
    a_both_edges: assert property (
        @(posedge core_clk) disable iff (rst)
        clr_n_s && store_edge && shift_edge |=>
        store_r == {$past(chain_r[7]), chain_r[7:1]})
        else $error("coincident edges stored post-shift data");
    a_store_hold: assert property (
        @(posedge core_clk) disable iff (rst)
        !(clr_n_s && store_edge) |=> $stable(store_r))
        else $error("storage changed without storage edge");

    // Cascade follows the last stage and ignores the enable.
    a_cascade_tail: assert property (
        @(posedge core_clk) disable iff (rst)
        ##1 cascade_out == chain_r[7])
        else $error("cascade not last stage");
    a_cascade_no_oe: assert property (
        @(posedge core_clk) disable iff (rst)
        $changed(oe_n_s) && clr_n_s && !shift_edge |=>
        $stable(cascade_out))
        else $error("enable change moved cascade output");

    // Main scenarios that the bench is expected to reach.
    c_shift: cover property (@(posedge core_clk) disable iff (rst)
        clr_n_s && shift_edge);
    c_store: cover property (@(posedge core_clk) disable iff (rst)
        clr_n_s && store_edge);
    c_both: cover property (@(posedge core_clk) disable iff (rst)
        clr_n_s && store_edge && shift_edge);
    c_clear: cover property (@(posedge core_clk) disable iff (rst)
        !clr_n_s ##1 clr_n_s);
    c_enable: cover property (@(posedge core_clk) disable iff (rst)
        oe_n_s ##1 !oe_n_s);
endmodule // serial_shift_storage_outputs

// file: core/shift_store_pkg.sv
package shift_store_pkg;
    // =====================================================================
    // Geometry and synchroniser depth.
    localparam int unsigned STAGES     = 8;
    localparam int unsigned SYNC_DEPTH = 2;
    // Reset values of the shift chain, storage register, clock edge detectors and cascade output.
    localparam logic [7:0]  CHAIN_RESET = 8'h00;
    localparam logic [7:0]  STORE_RESET = 8'h00;
    localparam logic        PIN_RESET   = 1'b0;
    // Idle level of each controller pin, in the order data, shift clock,
    // clear, storage clock, enable; synchronisers reset to these levels.
    localparam logic [4:0]  PINS_IDLE   = 5'h05;
    // Output enable value for a high-impedance pin (enable is active low).
    localparam logic [7:0]  OE_N_FLOAT  = 8'hff;
endpackage

// file: core/pin_sync.sv
// =========================================================================
// Two-flop synchroniser for one group of pin inputs.
module pin_sync #(
    parameter int unsigned  W    = 1,
    parameter logic [W-1:0] IDLE = '0
) (
    // Clock and reset
    input  wire logic         core_clk,
    input  wire logic         rst,
    // Asynchronous pins in, synchronised levels out
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] pin_out
);
    logic [W-1:0] meta_r;
    logic [W-1:0] meta_nxt;
    logic [W-1:0] sync_r;
    logic [W-1:0] sync_nxt;

    // The first stage feeds only the second stage.
    always_comb begin
        meta_nxt = pin_in;
        sync_nxt = meta_r;
    end

    // Registers settle to the pins' idle levels under reset.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            meta_r <= IDLE;
            sync_r <= IDLE;
        end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
        end
    end

    assign pin_out = sync_r;
endmodule // pin_sync

// file: tb/gpio_host.sv
// =====================================================================
// Controller pin model: plain output pins with a 160 ns link clock.
module gpio_host (
    // Core clock, used only to time pin changes
    input  wire logic core_clk,
    // Controller pins
    output logic      data_pin,
    output logic      shift_pin,
    output logic      store_pin,
    output logic      clear_n_pin,
    output logic      enable_n_pin
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int HALF = 10; // Half a link period in core cycles.

    // Clocks rest low so the release of reset sees no false edge.
    initial begin
        data_pin = 1'b0;
        shift_pin = 1'b0;
        store_pin = 1'b0;
        clear_n_pin = 1'b1;
        enable_n_pin = 1'b1;
    end

    // One link period: data settles half a period before the rise.
    task automatic pulse(input logic d, input logic sh, input logic st);
        @(posedge core_clk) #1;
        data_pin = d;
        repeat (HALF) @(posedge core_clk);
        #1;
        shift_pin = sh;
        store_pin = st;
        repeat (HALF) @(posedge core_clk);
        #1;
        shift_pin = 1'b0;
        store_pin = 1'b0;
    endtask

    // Level pins; waiting a half period lets the synchronisers settle.
    task automatic set_pins(input logic clr_n, input logic en_n);
        @(posedge core_clk) #1;
        clear_n_pin = clr_n;
        enable_n_pin = en_n;
        repeat (HALF) @(posedge core_clk);
    endtask
endmodule // gpio_host

// file: tb/serial_shift_storage_outputs_tb.sv
// =====================================================================
// Bench for the shift and storage register block.
module serial_shift_storage_outputs_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic       core_clk = 1'b0;
    logic       rst = 1'b1;
    logic       d_pin, sh_pin, st_pin, clr_n, en_n, cascade;
    logic [7:0] q_o, q_oe_n;
    wire  [7:0] par_pins;
    int         n_fail = 0;
    int         check_count = 0;
    int         cycles = 0;

    // Core clock at 125 MHz.
    always #4 core_clk = ~core_clk;

    // Resolve each three-state pin from its value and enable.
    for (genvar i = 0; i < 8; i++) begin : g_pin
        assign par_pins[i] = q_oe_n[i] ? 1'bz : q_o[i];
    end

    serial_shift_storage_outputs u_serial_shift_storage_outputs (
        .core_clk(core_clk), .rst(rst), .shift_data_in(d_pin),
        .shift_clock(sh_pin), .shift_clear_n(clr_n),
        .store_clock(st_pin), .out_enable_n(en_n),
        .par_outputs_o(q_o), .par_outputs_oe_n(q_oe_n),
        .cascade_out(cascade));
    gpio_host u_gpio_host (
        .core_clk(core_clk), .data_pin(d_pin), .shift_pin(sh_pin),
        .store_pin(st_pin), .clear_n_pin(clr_n), .enable_n_pin(en_n));

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d failures %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Whole run needs about 380 cycles; a hang is cut at 5000.
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_fail++;
            finish_test();
        end
    end

    // Clear, release the clear, then store: the outputs become defined
    // and stay floating until the enable pin goes low.
    task automatic power_up();
        check(par_pins, 8'hzz);
        u_gpio_host.set_pins(1'b0, 1'b1);
        u_gpio_host.set_pins(1'b1, 1'b1);
        u_gpio_host.pulse(1'b0, 1'b0, 1'b1);
        check(par_pins, 8'hzz);
        u_gpio_host.set_pins(1'b1, 1'b0);
        check(par_pins, 8'h00);
    endtask

    // Shift a byte first bit first; pins hold until the store edge.
    task automatic shift_and_store();
        logic [7:0] pat;
        pat = 8'ha5;
        for (int i = 7; i >= 0; i--) begin
            u_gpio_host.pulse(pat[i], 1'b1, 1'b0);
            check(par_pins, 8'h00);
        end
        check({7'h00, cascade}, 8'h01);
        u_gpio_host.set_pins(1'b1, 1'b1);
        check(par_pins, 8'hzz);
        check({7'h00, cascade}, 8'h01);
        u_gpio_host.set_pins(1'b1, 1'b0);
        u_gpio_host.pulse(1'b0, 1'b0, 1'b1);
        check(par_pins, pat);
    endtask

    // Coincident edges store the old contents, then shift; the cascade
    // pin then carries the bit that a chained device would take next.
    task automatic coincide_and_clear();
        u_gpio_host.pulse(1'b1, 1'b1, 1'b1);
        check(par_pins, 8'ha5);
        check({7'h00, cascade}, 8'h00);
        u_gpio_host.pulse(1'b0, 1'b0, 1'b1);
        check(par_pins, 8'h4b);
        u_gpio_host.set_pins(1'b0, 1'b0);
        u_gpio_host.pulse(1'b1, 1'b1, 1'b0);
        check(par_pins, 8'h4b);
        u_gpio_host.set_pins(1'b1, 1'b0);
        u_gpio_host.pulse(1'b0, 1'b0, 1'b1);
        check(par_pins, 8'h00);
    endtask

    // Reset for three cycles, then run every scenario.
    initial begin
        repeat (3) @(posedge core_clk);
        #1 rst = 1'b0;
        repeat (3) @(posedge core_clk);
        power_up();
        shift_and_store();
        coincide_and_clear();
        finish_test();
    end
endmodule // serial_shift_storage_outputs_tb
